//--- hdl/amove_top.sv
// Additive move handshake sequencer with Avalon-MM register access
`timescale 1ns/1ps
`include "amove_consts.svh"
module amove_top
	import amove_pkg::*;
#(
	parameter int DIST_W = `AMOVE_DIST_W
) (
	input wire logic sys_clk, // 10 MHz, one tick per controller period
	input wire logic rst_b,
	// Program side
	input wire logic trigger,
	input wire logic [2:0] queueing_policy,
	input wire logic [DIST_W-1:0] distance,
	output logic done,
	output logic busy,
	output logic active,
	output logic preempted_flag,
	output logic error,
	output logic [15:0] fault_code,
	// Axis side
	input wire amove_prior_t prior_kind,
	input wire logic [DIST_W-1:0] prior_remain,
	input wire logic overlay_run,
	input wire logic [DIST_W-1:0] overlay_remain,
	input wire logic axis_done,
	input wire logic axis_alarm,
	input wire logic axis_offline,
	input wire logic other_abort,
	output logic move_start,
	output logic [DIST_W-1:0] move_travel,
	output logic abort_prior,
	output logic abort_overlay,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq
);
	amove_state_t state; // Sequencer state
	amove_state_t next_state;
	logic trig_q; // Trigger one period ago
	logic trig_rise;
	logic trig_fall;
	logic fell_during; // Trigger dropped while running
	logic [2:0] policy_q; // Policy latched at trigger rise
	logic [DIST_W-1:0] dist_q; // Distance latched at trigger rise
	logic [DIST_W-1:0] plan_travel;
	logic plan_abort_prior;
	logic plan_abort_overlay;
	logic plan_wait;
	logic plan_reject;
	logic [15:0] plan_code;
	logic axis_fault;
	logic ev_done; // One-period events
	logic ev_abort;
	logic ev_error;
	logic [2:0] irq_status; // Sticky: done, abort, error
	logic [2:0] irq_mask;
	logic rd_ack; // Read answers one cycle after request
	logic [31:0] next_rdata;

	assign trig_rise = trigger & ~trig_q;
	assign trig_fall = ~trigger & trig_q;
	assign axis_fault = axis_alarm | axis_offline;

	// Edge detection of the trigger level
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= trigger;
		end
	end

	// Latch inputs at the start edge only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			policy_q <= `AMOVE_POLICY_ABORT;
			dist_q <= '0;
		end else if (trig_rise && state == AMOVE_IDLE) begin
			policy_q <= queueing_policy;
			dist_q <= distance;
		end
	end

	// Planner sees the latched request against current axis activity
	amove_plan #(
		.DIST_W(DIST_W)
	) u_plan (
		.distance(dist_q),
		.policy(policy_q),
		.prior_kind(prior_kind),
		.prior_remain(prior_remain),
		.overlay_run(overlay_run),
		.overlay_remain(overlay_remain),
		.travel(plan_travel),
		.abort_prior(plan_abort_prior),
		.abort_overlay(plan_abort_overlay),
		.wait_prior(plan_wait),
		.reject(plan_reject),
		.reject_code(plan_code)
	);

	// Terminating events, priority error over abort over done
	always_comb begin
		ev_error = 1'b0;
		ev_abort = 1'b0;
		ev_done = 1'b0;
		case (state)
			AMOVE_START: begin
				ev_error = plan_reject | axis_fault;
				// An abort in the launch period still counts as preemption
				ev_abort = ~plan_reject & ~axis_fault & other_abort;
			end
			AMOVE_WAIT: begin
				ev_error = axis_fault;
				ev_abort = ~axis_fault & other_abort;
			end
			AMOVE_RUN: begin
				ev_error = axis_fault;
				ev_abort = ~axis_fault & other_abort;
				ev_done = ~axis_fault & ~other_abort & axis_done;
			end
			default: begin
				ev_error = 1'b0;
			end
		endcase
	end

	// Sequencer transitions
	always_comb begin
		next_state = state;
		case (state)
			AMOVE_IDLE: begin
				// Re-edges are only looked at here, so a running move
				// ignores them
				if (trig_rise) begin
					next_state = AMOVE_START;
				end
			end
			AMOVE_START: begin
				if (ev_error || ev_abort) begin
					next_state = AMOVE_END;
				end else if (plan_wait) begin
					next_state = AMOVE_WAIT;
				end else begin
					next_state = AMOVE_RUN;
				end
			end
			AMOVE_WAIT: begin
				if (ev_error || ev_abort) begin
					next_state = AMOVE_END;
				end else if (prior_kind == AMOVE_PRIOR_NONE) begin
					next_state = AMOVE_RUN;
				end
			end
			AMOVE_RUN: begin
				if (ev_error || ev_abort || ev_done) begin
					next_state = AMOVE_END;
				end
			end
			AMOVE_END: begin
				// Flags stand; back to idle once they are cleared
				if (!trigger || fell_during) begin
					next_state = AMOVE_IDLE;
				end
			end
			default: begin
				next_state = AMOVE_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= AMOVE_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Remember a trigger drop that happened mid-move
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fell_during <= 1'b0;
		end else if (state == AMOVE_IDLE) begin
			fell_during <= 1'b0;
		end else if (trig_fall && state != AMOVE_END) begin
			fell_during <= 1'b1;
		end
	end

	// Busy from the rise edge period, Active one period later
	always_comb begin
		busy = (state == AMOVE_START) || (state == AMOVE_WAIT) ||
			(state == AMOVE_RUN);
		// A queued move is not yet steering the axis, so no Active
		active = (state == AMOVE_RUN);
	end

	// Done flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			done <= 1'b0;
		end else if (ev_done) begin
			done <= 1'b1;
		end else if (done && (fell_during || trig_fall)) begin
			// Early drop gives one period; else wait for fall
			done <= 1'b0;
		end
	end

	// Preempted flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			preempted_flag <= 1'b0;
		end else if (ev_abort) begin
			preempted_flag <= 1'b1;
		end else if (preempted_flag && (fell_during || trig_fall)) begin
			preempted_flag <= 1'b0;
		end
	end

	// Error flag and fault code; code clears with the flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			error <= 1'b0;
			fault_code <= `AMOVE_FAULT_NONE;
		end else if (ev_error) begin
			error <= 1'b1;
			if (axis_alarm) begin
				fault_code <= `AMOVE_FAULT_ALARM;
			end else if (axis_offline) begin
				fault_code <= `AMOVE_FAULT_OFFLINE;
			end else begin
				fault_code <= plan_code;
			end
		end else if (error && (fell_during || trig_fall)) begin
			// An early drop also releases the error after one period
			error <= 1'b0;
			fault_code <= `AMOVE_FAULT_NONE;
		end
	end

	// Commands toward the axis; start and aborts are one-period pulses, travel is held
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			move_start <= 1'b0;
			move_travel <= '0;
			abort_prior <= 1'b0;
			abort_overlay <= 1'b0;
		end else begin
			move_start <= (next_state == AMOVE_RUN) && (state != AMOVE_RUN);
			abort_prior <= (state == AMOVE_START) && !ev_error &&
				!ev_abort && plan_abort_prior;
			abort_overlay <= (state == AMOVE_START) && !ev_error &&
				!ev_abort && plan_abort_overlay;
			if (state == AMOVE_START || state == AMOVE_WAIT) begin
				move_travel <= plan_travel;
			end
		end
	end

	// Sticky event status; set wins over the clearing read
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (irq_status &
				~((rd_ack && avs_address == 4'h2) ? 3'h7 : 3'h0)) |
				{ev_error, ev_abort, ev_done};
		end
	end

	// Mask register, low byte lane only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_mask <= 3'h0;
		end else if (avs_write && avs_address == 4'h3 && avs_byteenable[0]) begin
			irq_mask <= avs_writedata[2:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Read mux: 0 flags, 1 fault code, 2 status, 3 mask, else zero
	always_comb begin
		case (avs_address)
			4'h0: next_rdata = {26'h0, preempted_flag, error, active, busy,
				done, trigger};
			4'h1: next_rdata = {16'h0, fault_code};
			4'h2: next_rdata = {29'h0, irq_status};
			4'h3: next_rdata = {29'h0, irq_mask};
			default: next_rdata = 32'h0;
		endcase
	end

	// Reads wait one cycle so data come from a flop; writes never wait
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			rd_ack <= avs_read && !rd_ack;
			if (avs_read && !rd_ack) begin
				avs_readdata <= next_rdata;
			end
		end
	end

	assign avs_waitrequest = avs_read && !rd_ack;
endmodule

//--- hdl/amove_consts.svh
// Constants for the additive move command handshake block
`ifndef AMOVE_CONSTS_SVH
`define AMOVE_CONSTS_SVH
`define AMOVE_POLICY_ABORT 3'h0
`define AMOVE_POLICY_MAX 3'h5
`define AMOVE_FAULT_NONE 16'h0000
`define AMOVE_FAULT_ALARM 16'h0001
`define AMOVE_FAULT_OFFLINE 16'h0002
`define AMOVE_FAULT_PARAM 16'h0003
`define AMOVE_FAULT_OVERLAY 16'h0004
`define AMOVE_FAULT_POLICY 16'h0005
`define AMOVE_DIST_W 32
`endif

//--- hdl/amove_pkg.sv
// Types for the additive move command handshake block
package amove_pkg;
	// One-hot sequencer states
	typedef enum logic [4:0] {
		AMOVE_IDLE = 5'b00001,
		AMOVE_START = 5'b00010,
		AMOVE_WAIT = 5'b00100,
		AMOVE_RUN = 5'b01000,
		AMOVE_END = 5'b10000
	} amove_state_t;
	// Kind of motion already in progress on the axis
	typedef enum logic [1:0] {
		AMOVE_PRIOR_NONE = 2'h0,
		AMOVE_PRIOR_POS = 2'h1,
		AMOVE_PRIOR_VEL = 2'h2
	} amove_prior_t;
endpackage

//--- hdl/amove_plan.sv
// Start planner: travel sum and queueing decision at trigger rise
`timescale 1ns/1ps
`include "amove_consts.svh"
module amove_plan
	import amove_pkg::*;
#(
	parameter int DIST_W = `AMOVE_DIST_W
) (
	input wire logic [DIST_W-1:0] distance,
	input wire logic [2:0] policy,
	input wire amove_prior_t prior_kind,
	input wire logic [DIST_W-1:0] prior_remain,
	input wire logic overlay_run,
	input wire logic [DIST_W-1:0] overlay_remain,
	output logic [DIST_W-1:0] travel,
	output logic abort_prior,
	output logic abort_overlay,
	output logic wait_prior,
	output logic reject,
	output logic [15:0] reject_code
);
	logic aborting; // Policy zero means abort
	logic bad_policy; // Codes above five are illegal
	assign aborting = (policy == `AMOVE_POLICY_ABORT);
	assign bad_policy = (policy > `AMOVE_POLICY_MAX);

	// Decide travel and what to do with the motion in progress
	always_comb begin
		travel = distance;
		abort_prior = 1'b0;
		abort_overlay = 1'b0;
		wait_prior = 1'b0;
		reject = 1'b0;
		reject_code = `AMOVE_FAULT_NONE;
		if (bad_policy) begin
			reject = 1'b1;
			reject_code = `AMOVE_FAULT_POLICY;
		end else if (prior_kind == AMOVE_PRIOR_VEL) begin
			// Velocity command is dropped; own distance only
			abort_prior = 1'b1;
			abort_overlay = overlay_run;
		end else if (overlay_run && prior_kind == AMOVE_PRIOR_NONE) begin
			if (aborting) begin
				abort_overlay = 1'b1;
				travel = distance + overlay_remain;
			end else begin
				reject = 1'b1;
				reject_code = `AMOVE_FAULT_OVERLAY;
			end
		end else if (overlay_run) begin
			if (aborting) begin
				// Table form taken: both remainders are added
				abort_overlay = 1'b1;
				abort_prior = 1'b1;
				travel = distance + prior_remain + overlay_remain;
			end else begin
				wait_prior = 1'b1;
			end
		end else if (prior_kind == AMOVE_PRIOR_POS) begin
			// Additive semantics regardless of policy
			abort_prior = 1'b1;
			travel = distance + prior_remain;
		end
	end
endmodule

//--- dv/amove_axis_model.sv
// Axis drive model: prior motion, overlay and own move completion
`timescale 1ns/1ps
module amove_axis_model
	import amove_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic load, // Takes a new prior setup
	input wire amove_prior_t cfg_kind,
	input wire logic cfg_ovl,
	input wire logic [31:0] cfg_prem,
	input wire logic [31:0] cfg_orem,
	input wire logic [7:0] lat, // Launch to completion, cycles
	input wire logic move_start,
	input wire logic abort_prior,
	input wire logic abort_overlay,
	output amove_prior_t prior_kind,
	output logic [31:0] prior_remain,
	output logic overlay_run,
	output logic [31:0] overlay_remain,
	output logic axis_done
);
	logic [7:0] pcnt; // Prior positioning countdown
	logic [7:0] cnt; // Own move countdown
	// Countdowns; completion is a one-cycle level
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pcnt <= 8'h0;
			cnt <= 8'h0;
			axis_done <= 1'b0;
		end else begin
			pcnt <= load ? 8'h08 : pcnt - {7'h0, pcnt != 8'h0};
			cnt <= move_start ? lat : cnt - {7'h0, cnt != 8'h0};
			axis_done <= cnt == 8'h01;
		end
	end
	// Positioning ends alone; an aborted remainder is inverted
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prior_kind <= AMOVE_PRIOR_NONE;
			prior_remain <= 32'h0;
		end else if (load) begin
			prior_kind <= cfg_kind;
			prior_remain <= cfg_prem;
		end else if (abort_prior) begin
			prior_kind <= AMOVE_PRIOR_NONE;
			prior_remain <= ~prior_remain;
		end else if (pcnt == 8'h01 && prior_kind == AMOVE_PRIOR_POS) begin
			prior_kind <= AMOVE_PRIOR_NONE;
			prior_remain <= 32'h0;
		end
	end
	// Overlay keeps running until the block aborts it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			overlay_run <= 1'b0;
			overlay_remain <= 32'h0;
		end else if (load) begin
			overlay_run <= cfg_ovl;
			overlay_remain <= cfg_orem;
		end else if (abort_overlay) begin
			overlay_run <= 1'b0;
			overlay_remain <= ~overlay_remain;
		end
	end
endmodule

//--- dv/amove_top_props.sv
// Handshake checker for the additive move block
`timescale 1ns/1ps
module amove_top_props (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic trigger,
	input wire logic overlay_run,
	input wire logic other_abort,
	input wire logic done,
	input wire logic busy,
	input wire logic active,
	input wire logic preempted_flag,
	input wire logic error
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Rise is taken only from a clean idle
	property p_go;
		$rose(trigger) && !busy && !(done | error | preempted_flag) |=> busy;
	endproperty
	a_go: assert property (p_go) else $error("busy late");
	// A waiting overlay case may hold active back
	property p_act;
		$rose(busy) && !overlay_run |=> active | error;
	endproperty
	a_act: assert property (p_act) else $error("active late");
	property p_end;
		$rose(done | error | preempted_flag) |-> !busy && !active;
	endproperty
	a_end: assert property (p_end) else $error("busy after end");
	property p_dhold;
		done && trigger |=> done;
	endproperty
	a_dhold: assert property (p_dhold) else $error("done lost");
	property p_dpulse;
		$rose(done) && !trigger && !$past(trigger) |=> !done;
	endproperty
	a_dpulse: assert property (p_dpulse) else $error("done long");
	property p_ehold;
		error && trigger |=> error;
	endproperty
	a_ehold: assert property (p_ehold) else $error("error lost");
	property p_eclr;
		$fell(trigger) && error |-> ##[1:2] !error;
	endproperty
	a_eclr: assert property (p_eclr) else $error("error stuck");
	property p_pclr;
		$fell(trigger) && preempted_flag |-> ##[1:2] !preempted_flag;
	endproperty
	a_pclr: assert property (p_pclr) else $error("preempt stuck");
	property p_pset;
		busy && other_abort |-> ##[1:2] preempted_flag;
	endproperty
	a_pset: assert property (p_pset) else $error("preempt missing");
	// Main outcomes seen at least once
	c_done: cover property ($rose(done));
	c_err: cover property ($rose(error));
	c_pre: cover property ($rose(preempted_flag));
endmodule
bind amove_top amove_top_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.trigger(trigger), .overlay_run(overlay_run), .other_abort(other_abort),
	.done(done), .busy(busy), .active(active), .error(error),
	.preempted_flag(preempted_flag));

//--- dv/amove_top_tb_top.sv
// Testbench for the additive move handshake block
`timescale 1ns/1ps
`include "amove_consts.svh"
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("ERROR t=%0t got %h exp %h", $time, g, e); \
	end \
end
module amove_top_tb_top
	import amove_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b, trigger, axis_alarm, axis_offline, other_abort;
	logic avs_read, avs_write, load, cfg_ovl, done, busy, active;
	logic preempted_flag, error, move_start, abort_prior, abort_overlay;
	logic avs_waitrequest, irq, overlay_run, axis_done;
	logic [2:0] queueing_policy, fin, fin_q = 3'h0;
	logic [3:0] avs_address, avs_byteenable;
	logic [7:0] lat;
	logic [15:0] fault_code, fc;
	logic [31:0] distance, cfg_prem, cfg_orem, avs_writedata, avs_readdata;
	logic [31:0] move_travel, prior_remain, overlay_remain, x;
	logic [31:0] lfsr = 32'h37; // Fixed seed
	amove_prior_t cfg_kind, prior_kind;
	int bad_count, num_checks;
	logic [31:0] expq[$]; // Notes of expected results, oldest first
	assign fin = {preempted_flag, error, done};
	assign fc = error ? fault_code : 16'h0; // Code only counts with error
	amove_top u_dut (.*);
	amove_axis_model u_axis (.*);
	// 100 ns period
	always #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		if (!wr) expq.push_back(d);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) bad_count++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	// One move: set up the axis, trigger, end event, release
	task automatic go(input amove_prior_t pk, input logic ov,
		input logic [2:0] pol, input logic [1:0] ev, input logic hold);
		logic [31:0] d, p, o, e;
		logic wt, bad;
		int n;
		d = rnd();
		p = rnd();
		o = rnd();
		wt = ov && pk == AMOVE_PRIOR_POS && pol != 3'h0 && pol < 3'h6;
		bad = pol > 3'h5 || (ov && pk != AMOVE_PRIOR_POS && pol != 3'h0);
		if (bad) begin
			e = {16'h2, pol > 3'h5 ? `AMOVE_FAULT_POLICY : `AMOVE_FAULT_OVERLAY};
		end else begin
			expq.push_back(d + (pk == AMOVE_PRIOR_POS && !wt ? p : 32'h0)
				+ (ov && pol == 3'h0 ? o : 32'h0));
			e = ev == 2'h0 ? 32'h1_0000 : ev == 2'h3 ? 32'h4_0000 :
				{16'h2, ev[0] ? `AMOVE_FAULT_ALARM : `AMOVE_FAULT_OFFLINE};
		end
		expq.push_back(e);
		load <= 1'b1;
		cfg_kind <= pk;
		cfg_ovl <= ov;
		cfg_prem <= p;
		cfg_orem <= o;
		lat <= {4'h0, d[3:0]} + 8'h04; // Prompt to slow completion
		@(posedge sys_clk);
		load <= 1'b0;
		trigger <= 1'b1;
		queueing_policy <= pol;
		distance <= d;
		repeat (2) @(posedge sys_clk);
		`CHK({busy, active}, 2'b10)
		@(posedge sys_clk);
		`CHK(active, !bad && !wt)
		{other_abort, axis_offline, axis_alarm} <= 3'(4'b0001 << ev >> 1);
		if (!hold) trigger <= 1'b0;
		@(posedge sys_clk);
		{other_abort, axis_offline, axis_alarm} <= 3'h0;
		n = 0;
		while (fin === 3'h0 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(n < 300, 1'b1)
		trigger <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(fin, 3'h0)
		$display("move test ended, policy %0d", pol);
	endtask
	// Each result that appears is matched with the oldest note
	always @(posedge sys_clk) begin
		fin_q <= fin;
		if (move_start === 1'b1) begin
			x = expq.pop_front();
			`CHK(move_travel, x)
		end
		if (fin_q === 3'h0 && fin !== 3'h0) begin
			x = expq.pop_front();
			`CHK({13'h0, fin, fc}, x)
		end
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			x = expq.pop_front();
			`CHK(avs_readdata, x)
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Cuts a hung run short
	initial begin
		#1_000_000;
		bad_count++;
		tally_and_finish();
	end
	// Reset, registers and interrupt, then the move table
	initial begin
		{rst_b, trigger, axis_alarm, axis_offline, other_abort} = 5'h0;
		{avs_read, avs_write, load, cfg_ovl, queueing_policy} = 7'h0;
		{distance, cfg_prem, cfg_orem, avs_writedata} = 128'h0;
		{avs_address, avs_byteenable, lat} = 16'h0;
		cfg_kind = AMOVE_PRIOR_NONE;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		`CHK({fin, busy, active, irq, fault_code}, 22'h0)
		bus(1'b0, 4'h1, 32'h0);
		bus(1'b1, 4'h3, 32'h7);
		go(AMOVE_PRIOR_NONE, 1'b0, 3'h0, 2'h0, 1'b1);
		`CHK(irq, 1'b1)
		bus(1'b0, 4'h2, 32'h1);
		`CHK(irq, 1'b0)
		bus(1'b0, 4'h9, 32'h0);
		bus(1'b1, 4'h3, 32'h0);
		$display("register test ended");
		go(AMOVE_PRIOR_NONE, 1'b0, 3'h1, 2'h0, 1'b0);
		go(AMOVE_PRIOR_POS, 1'b0, 3'h0, 2'h0, 1'b1);
		go(AMOVE_PRIOR_VEL, 1'b0, 3'h0, 2'h0, 1'b1);
		go(AMOVE_PRIOR_NONE, 1'b1, 3'h0, 2'h0, 1'b1);
		for (int i = 1; i < 6; i++) begin
			go(AMOVE_PRIOR_NONE, 1'b1, i[2:0], 2'h0, 1'b1);
		end
		go(AMOVE_PRIOR_POS, 1'b1, 3'h0, 2'h0, 1'b1);
		go(AMOVE_PRIOR_POS, 1'b1, 3'h2, 2'h0, 1'b1);
		go(AMOVE_PRIOR_NONE, 1'b0, 3'h6, 2'h0, 1'b1);
		for (int i = 1; i < 4; i++) begin
			go(AMOVE_PRIOR_NONE, 1'b0, 3'h0, i[1:0], 1'b1);
		end
		go(AMOVE_PRIOR_NONE, 1'b0, 3'h0, 2'h3, 1'b0);
		`CHK(irq, 1'b0)
		tally_and_finish();
	end
endmodule
